/* logic/light_sensor_regs.sv */
`timescale 1ns/100ps
`default_nettype none
module light_sensor_regs (
   input  wire logic                    clk_sys,
   input  wire logic                    rst,
   input  wire logic                    sclIn,
   input  wire logic                    sdaIn,
   output logic                         sdaOut,
   output logic                         sdaOeN,
   output logic                         intOut,
   output logic                         intOeN,
   input  wire logic                    convDone,
   input  wire light_sensor_pkg::conv_t convData,
   input  wire logic                    adcEnable,
   input  wire logic                    manualActive,
   output logic                         haltIntegration,
   output light_sensor_pkg::gain_t      gainSel
);
   // Bus engine state
   light_sensor_pkg::bus_state_t st_reg, st_next;
   logic       sclPrev_reg, sdaPrev_reg;
   logic [3:0] bitCnt_reg, bitCnt_next;
   logic [7:0] shift_reg, shift_next;
   logic       rnw_reg, rnw_next, first_reg, first_next, idx_reg, idx_next;
   logic [4:0] ptr_reg, ptr_next;
   logic       sdaOeN_reg, sdaOeN_next;
   logic       wrHit, rdHit, clrIrq;
   logic [4:0] accAddr;
   logic [7:0] rdData;
   logic       sclRise, sclFall, startCond, stopCond;

   // Register and interrupt state
   logic [7:0]  irqCtrl_reg, irqCtrl_next, analog_reg, analog_next, variant_reg, variant_next;
   logic [15:0] lowTh_reg, lowTh_next, highTh_reg, highTh_next;
   logic [15:0] ch0_reg, ch0_next, ch1_reg, ch1_next, timer_reg, timer_next;
   logic [7:0]  shadow0_reg, shadow0_next, shadow1_reg, shadow1_next;
   logic [10:0] presc_reg, presc_next;
   logic        manPrev_reg;
   logic [3:0]  persistCnt_reg, persistCnt_next, bumped;
   logic        irqPend_reg, irqPend_next, halt_reg, halt_next, intOeN_reg, intOeN_next;
   logic        convTaken, outOfWin;
   light_sensor_pkg::gain_t gain_reg, gain_next;

   assign sclRise   = sclIn & ~sclPrev_reg;
   assign sclFall   = ~sclIn & sclPrev_reg;
   assign startCond = sclIn & sclPrev_reg & sdaPrev_reg & ~sdaIn;
   assign stopCond  = sclIn & sclPrev_reg & ~sdaPrev_reg & sdaIn;
   assign accAddr   = ptr_reg + {4'h0, idx_reg};

   always_comb begin
      rdData = 8'h00;
      if (accAddr == light_sensor_pkg::OFF_IRQ_CTRL) begin
         rdData = irqCtrl_reg;
      end else if (accAddr == light_sensor_pkg::OFF_LOW_LSB) begin
         rdData = lowTh_reg[7:0];
      end else if (accAddr == light_sensor_pkg::OFF_LOW_MSB) begin
         rdData = lowTh_reg[15:8];
      end else if (accAddr == light_sensor_pkg::OFF_HIGH_LSB) begin
         rdData = highTh_reg[7:0];
      end else if (accAddr == light_sensor_pkg::OFF_HIGH_MSB) begin
         rdData = highTh_reg[15:8];
      end else if (accAddr == light_sensor_pkg::OFF_ANALOG) begin
         rdData = analog_reg;
      end else if (accAddr == light_sensor_pkg::OFF_PART_REV) begin
         rdData = {light_sensor_pkg::PART_CODE, light_sensor_pkg::SILICON_REV};
      end else if (accAddr == light_sensor_pkg::OFF_CH0_LSB) begin
         rdData = ch0_reg[7:0];
      end else if (accAddr == light_sensor_pkg::OFF_CH0_MSB) begin
         rdData = shadow0_reg;
      end else if (accAddr == light_sensor_pkg::OFF_CH1_LSB) begin
         rdData = ch1_reg[7:0];
      end else if (accAddr == light_sensor_pkg::OFF_CH1_MSB) begin
         rdData = shadow1_reg;
      end else if (accAddr == light_sensor_pkg::OFF_TIMER_LSB) begin
         rdData = timer_reg[7:0];
      end else if (accAddr == light_sensor_pkg::OFF_TIMER_MSB) begin
         rdData = timer_reg[15:8];
      end else if (accAddr == light_sensor_pkg::OFF_VARIANT) begin
         rdData = variant_reg;
      end
   end

   always_comb begin
      st_next     = st_reg;
      bitCnt_next = bitCnt_reg;
      shift_next  = shift_reg;
      rnw_next    = rnw_reg;
      first_next  = first_reg;
      idx_next    = idx_reg;
      ptr_next    = ptr_reg;
      sdaOeN_next = sdaOeN_reg;
      wrHit       = 1'b0;
      rdHit       = 1'b0;
      clrIrq      = 1'b0;
      if (startCond) begin
         st_next     = light_sensor_pkg::BUS_ADDR;
         bitCnt_next = 4'h0;
         sdaOeN_next = 1'b1;
      end else if (stopCond) begin
         st_next     = light_sensor_pkg::BUS_IDLE;
         sdaOeN_next = 1'b1;
      end else begin
         case (st_reg)
            light_sensor_pkg::BUS_ADDR, light_sensor_pkg::BUS_WRITE: begin
               if (sclRise) begin
                  shift_next  = {shift_reg[6:0], sdaIn};
                  bitCnt_next = bitCnt_reg + 4'h1;
               end else if (sclFall && bitCnt_reg == light_sensor_pkg::BITS_PER_BYTE) begin
                  bitCnt_next = 4'h0;
                  if (st_reg == light_sensor_pkg::BUS_WRITE) begin
                     sdaOeN_next = 1'b0;
                     st_next     = light_sensor_pkg::BUS_ACK;
                     if (first_reg && shift_reg[light_sensor_pkg::CMD_FLAG_BIT]) begin
                        ptr_next = shift_reg[4:0];
                        idx_next = 1'b0;
                        clrIrq   = (shift_reg[6:5] == light_sensor_pkg::TRANS_SPECIAL);
                     end else begin
                        wrHit    = 1'b1;
                        idx_next = ~idx_reg;
                     end
                     first_next = 1'b0;
                  end else if (shift_reg[7:1] == light_sensor_pkg::SLAVE_ADDR) begin
                     sdaOeN_next = 1'b0;
                     rnw_next    = shift_reg[0];
                     first_next  = 1'b1;
                     idx_next    = 1'b0;
                     st_next     = light_sensor_pkg::BUS_ACK;
                  end else begin
                     st_next = light_sensor_pkg::BUS_IDLE;
                  end
               end
            end
            light_sensor_pkg::BUS_ACK: begin
               if (sclFall) begin
                  if (rnw_reg) begin
                     rdHit       = 1'b1;
                     shift_next  = rdData;
                     sdaOeN_next = rdData[7];
                     bitCnt_next = 4'h1;
                     idx_next    = ~idx_reg;
                     st_next     = light_sensor_pkg::BUS_READ;
                  end else begin
                     sdaOeN_next = 1'b1;
                     st_next     = light_sensor_pkg::BUS_WRITE;
                  end
               end
            end
            light_sensor_pkg::BUS_READ: begin
               if (sclFall) begin
                  if (bitCnt_reg == light_sensor_pkg::BITS_PER_BYTE) begin
                     sdaOeN_next = 1'b1;
                     bitCnt_next = 4'h0;
                     st_next     = light_sensor_pkg::BUS_MACK;
                  end else begin
                     shift_next  = {shift_reg[6:0], 1'b0};
                     sdaOeN_next = shift_reg[6];
                     bitCnt_next = bitCnt_reg + 4'h1;
                  end
               end
            end
            light_sensor_pkg::BUS_MACK: begin
               if (sclRise) begin
                  st_next = sdaIn ? light_sensor_pkg::BUS_IDLE : light_sensor_pkg::BUS_ACK;
               end
            end
            default: begin
               st_next = light_sensor_pkg::BUS_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_reg      <= light_sensor_pkg::BUS_IDLE;
         sclPrev_reg <= 1'b1;
         sdaPrev_reg <= 1'b1;
         bitCnt_reg  <= 4'h0;
         shift_reg   <= 8'h00;
         rnw_reg     <= 1'b0;
         first_reg   <= 1'b0;
         idx_reg     <= 1'b0;
         ptr_reg     <= 5'h00;
         sdaOeN_reg  <= 1'b1;
      end else begin
         st_reg      <= st_next;
         sclPrev_reg <= sclIn;
         sdaPrev_reg <= sdaIn;
         bitCnt_reg  <= bitCnt_next;
         shift_reg   <= shift_next;
         rnw_reg     <= rnw_next;
         first_reg   <= first_next;
         idx_reg     <= idx_next;
         ptr_reg     <= ptr_next;
         sdaOeN_reg  <= sdaOeN_next;
      end
   end

   // A halted converter still raises convDone upstream; results are frozen then
   assign convTaken = convDone & ~halt_reg;
   assign outOfWin  = (convData.ch0 <= lowTh_reg) || (convData.ch0 > highTh_reg);
   assign bumped    = (persistCnt_reg == light_sensor_pkg::PERSIST_MAX) ?
                      light_sensor_pkg::PERSIST_MAX : persistCnt_reg + 4'h1;

   always_comb begin
      irqCtrl_next    = irqCtrl_reg;
      lowTh_next      = lowTh_reg;
      highTh_next     = highTh_reg;
      analog_next     = analog_reg;
      variant_next    = variant_reg;
      ch0_next        = ch0_reg;
      ch1_next        = ch1_reg;
      shadow0_next    = shadow0_reg;
      shadow1_next    = shadow1_reg;
      persistCnt_next = persistCnt_reg;
      irqPend_next    = irqPend_reg & ~clrIrq;
      presc_next      = presc_reg;
      timer_next      = timer_reg;
      if (wrHit) begin
         if (accAddr == light_sensor_pkg::OFF_IRQ_CTRL) begin
            irqCtrl_next = shift_reg & light_sensor_pkg::IRQ_CTRL_MASK;
         end else if (accAddr == light_sensor_pkg::OFF_LOW_LSB) begin
            lowTh_next[7:0] = shift_reg;
         end else if (accAddr == light_sensor_pkg::OFF_LOW_MSB) begin
            lowTh_next[15:8] = shift_reg;
         end else if (accAddr == light_sensor_pkg::OFF_HIGH_LSB) begin
            highTh_next[7:0] = shift_reg;
         end else if (accAddr == light_sensor_pkg::OFF_HIGH_MSB) begin
            highTh_next[15:8] = shift_reg;
         end else if (accAddr == light_sensor_pkg::OFF_ANALOG) begin
            analog_next = shift_reg & light_sensor_pkg::ANALOG_MASK;
         end else if (accAddr == light_sensor_pkg::OFF_VARIANT) begin
            variant_next = shift_reg;
         end
      end
      if (rdHit && accAddr == light_sensor_pkg::OFF_CH0_LSB) begin
         shadow0_next = ch0_reg[15:8];
      end
      if (rdHit && accAddr == light_sensor_pkg::OFF_CH1_LSB) begin
         shadow1_next = ch1_reg[15:8];
      end
      if (convTaken) begin
         ch0_next = convData.ch0;
         ch1_next = convData.ch1;
         if (outOfWin) begin
            persistCnt_next = bumped;
         end else begin
            persistCnt_next = 4'h0;
         end
         if (irqCtrl_reg[light_sensor_pkg::MODE_BIT]) begin
            if (irqCtrl_reg[3:0] == light_sensor_pkg::PERSIST_EVERY) begin
               irqPend_next = 1'b1;
            end else if (outOfWin && bumped >= irqCtrl_reg[3:0]) begin
               irqPend_next = 1'b1;
            end
         end
      end
      if (manualActive && !manPrev_reg) begin
         presc_next = 11'h000;
         timer_next = 16'h0000;
      end else if (manualActive) begin
         if (presc_reg == light_sensor_pkg::TIMER_WRAP) begin
            presc_next = 11'h000;
            timer_next = timer_reg + 16'h0001;
         end else begin
            presc_next = presc_reg + 11'h001;
         end
      end
      // Resume needs enable low and interrupt cleared before enable returns
      halt_next   = halt_reg ? (adcEnable | irqPend_reg) :
                    (irqCtrl_reg[light_sensor_pkg::HALT_BIT] & irqPend_reg);
      intOeN_next = ~(irqPend_next & irqCtrl_reg[light_sensor_pkg::MODE_BIT]);
      gain_next   = light_sensor_pkg::gain_t'(analog_reg[1:0]);
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         irqCtrl_reg    <= light_sensor_pkg::BYTE_RESET;
         lowTh_reg      <= {light_sensor_pkg::BYTE_RESET, light_sensor_pkg::BYTE_RESET};
         highTh_reg     <= {light_sensor_pkg::BYTE_RESET, light_sensor_pkg::BYTE_RESET};
         analog_reg     <= light_sensor_pkg::BYTE_RESET;
         variant_reg    <= {2'h0, light_sensor_pkg::VARIANT_CODE, 4'h0};
         ch0_reg        <= 16'h0000;
         ch1_reg        <= 16'h0000;
         shadow0_reg    <= light_sensor_pkg::BYTE_RESET;
         shadow1_reg    <= light_sensor_pkg::BYTE_RESET;
         persistCnt_reg <= 4'h0;
         irqPend_reg    <= 1'b0;
         halt_reg       <= 1'b0;
         intOeN_reg     <= 1'b1;
         presc_reg      <= 11'h000;
         timer_reg      <= 16'h0000;
         manPrev_reg    <= 1'b0;
         gain_reg       <= light_sensor_pkg::GAIN_1X;
      end else begin
         irqCtrl_reg    <= irqCtrl_next;
         lowTh_reg      <= lowTh_next;
         highTh_reg     <= highTh_next;
         analog_reg     <= analog_next;
         variant_reg    <= variant_next;
         ch0_reg        <= ch0_next;
         ch1_reg        <= ch1_next;
         shadow0_reg    <= shadow0_next;
         shadow1_reg    <= shadow1_next;
         persistCnt_reg <= persistCnt_next;
         irqPend_reg    <= irqPend_next;
         halt_reg       <= halt_next;
         intOeN_reg     <= intOeN_next;
         presc_reg      <= presc_next;
         timer_reg      <= timer_next;
         manPrev_reg    <= manualActive;
         gain_reg       <= gain_next;
      end
   end

   assign sdaOut          = 1'b0;
   assign intOut          = 1'b0;
   assign sdaOeN          = sdaOeN_reg;
   assign intOeN          = intOeN_reg;
   assign haltIntegration = halt_reg;
   assign gainSel         = gain_reg;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   property p_irq_off;
      !irqCtrl_reg[light_sensor_pkg::MODE_BIT] |=> intOeN_reg;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("interrupt driven while disabled");

   property p_every_conv;
      convTaken && irqCtrl_reg[light_sensor_pkg::MODE_BIT] && irqCtrl_reg[3:0] == 4'h0
         |=> irqPend_reg && !intOeN_reg;
   endproperty
   a_every_conv: assert property (p_every_conv) else $error("no end-of-conversion irq");

   property p_low_hit;
      convTaken && irqCtrl_reg[4] && irqCtrl_reg[3:0] == 4'h1 && convData.ch0 <= lowTh_reg
         |=> irqPend_reg;
   endproperty
   a_low_hit: assert property (p_low_hit) else $error("low threshold missed");

   property p_high_hit;
      convTaken && irqCtrl_reg[4] && irqCtrl_reg[3:0] == 4'h1 && convData.ch0 > highTh_reg
         |=> irqPend_reg;
   endproperty
   a_high_hit: assert property (p_high_hit) else $error("high threshold missed");

   property p_persist_wait;
      // Saturated count must not wrap into a false "too early" verdict
      convTaken && !irqPend_reg && irqCtrl_reg[3:0] >= 4'h2 && !clrIrq
         && persistCnt_reg < irqCtrl_reg[3:0] - 4'h1 |=> !irqPend_reg;
   endproperty
   a_persist_wait: assert property (p_persist_wait) else $error("irq before persistence");

   property p_count_reset;
      convTaken && !outOfWin |=> persistCnt_reg == 4'h0;
   endproperty
   a_count_reset: assert property (p_count_reset) else $error("count not cleared");

   property p_sticky;
      irqPend_reg && !clrIrq |=> irqPend_reg;
   endproperty
   a_sticky: assert property (p_sticky) else $error("interrupt dropped uncleared");

   property p_shadow;
      rdHit && accAddr == light_sensor_pkg::OFF_CH0_LSB |=> shadow0_reg == $past(ch0_reg[15:8])
         ##1 (rdHit || $stable(shadow0_reg));
   endproperty
   a_shadow: assert property (p_shadow) else $error("shadow capture wrong");

   property p_halt_hold;
      halt_reg && adcEnable |=> halt_reg ##0 $stable(ch0_reg);
   endproperty
   a_halt_hold: assert property (p_halt_hold) else $error("halt released early");
endmodule : light_sensor_regs
`default_nettype wire

/* logic/light_sensor_pkg.sv */
`default_nettype none
package light_sensor_pkg;
   localparam logic [6:0] SLAVE_ADDR      = 7'h39;
   localparam int         CMD_FLAG_BIT    = 7;
   localparam logic [1:0] TRANS_SPECIAL   = 2'h3;
   localparam logic [4:0] OFF_IRQ_CTRL    = 5'h02;
   localparam logic [4:0] OFF_LOW_LSB     = 5'h03;
   localparam logic [4:0] OFF_LOW_MSB     = 5'h04;
   localparam logic [4:0] OFF_HIGH_LSB    = 5'h05;
   localparam logic [4:0] OFF_HIGH_MSB    = 5'h06;
   localparam logic [4:0] OFF_ANALOG      = 5'h07;
   localparam logic [4:0] OFF_PART_REV    = 5'h12;
   localparam logic [4:0] OFF_CH0_LSB     = 5'h14;
   localparam logic [4:0] OFF_CH0_MSB     = 5'h15;
   localparam logic [4:0] OFF_CH1_LSB     = 5'h16;
   localparam logic [4:0] OFF_CH1_MSB     = 5'h17;
   localparam logic [4:0] OFF_TIMER_LSB   = 5'h18;
   localparam logic [4:0] OFF_TIMER_MSB   = 5'h19;
   localparam logic [4:0] OFF_VARIANT     = 5'h1E;
   localparam int         HALT_BIT        = 6;
   localparam int         MODE_BIT        = 4;
   localparam logic [7:0] IRQ_CTRL_MASK   = 8'h5F;
   localparam logic [7:0] ANALOG_MASK     = 8'h07;
   localparam logic [7:0] BYTE_RESET      = 8'h00;
   localparam logic [3:0] PERSIST_EVERY   = 4'h0;
   localparam logic [3:0] PERSIST_MAX     = 4'hF;
   // Arbitrary identity values
   localparam logic [3:0] PART_CODE       = 4'h5;
   localparam logic [3:0] SILICON_REV     = 4'h2;
   localparam logic [1:0] VARIANT_CODE    = 2'h1;
   localparam logic [3:0] BITS_PER_BYTE   = 4'h8;
   localparam real        CLK_PERIOD_NS   = 10.0;
   localparam real        TIMER_UNIT_US   = 10.9;
   localparam int         TIMER_UNIT_CYC  = int'($floor(TIMER_UNIT_US * 1000.0 / CLK_PERIOD_NS));
   localparam logic [10:0] TIMER_WRAP     = 11'(TIMER_UNIT_CYC - 1);

   typedef enum logic [5:0] {
      BUS_IDLE  = 6'h01,
      BUS_ADDR  = 6'h02,
      BUS_ACK   = 6'h04,
      BUS_WRITE = 6'h08,
      BUS_READ  = 6'h10,
      BUS_MACK  = 6'h20
   } bus_state_t;

   typedef enum logic [1:0] {
      GAIN_1X = 2'h0, GAIN_8X = 2'h1, GAIN_16X = 2'h2, GAIN_111X = 2'h3
   } gain_t;

   typedef struct packed {
      logic [15:0] ch0;
      logic [15:0] ch1;
   } conv_t;
endpackage : light_sensor_pkg
`default_nettype wire

/* sim/i2c_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module i2c_host_model (
   input  wire logic clk_sys,
   input  wire logic sdaOeN,
   output logic      sclLine,
   output logic      sdaLine,
   output logic      nackSeen
);
   logic sdaDrv = 1'b1;
   initial sclLine = 1'b1;
   initial nackSeen = 1'b0;
   // Open drain with pull-up
   assign sdaLine = sdaDrv & sdaOeN;
   task automatic hold();
      repeat (4) @(posedge clk_sys);
   endtask : hold
   task automatic bit_io(input logic b, output logic r);
      sdaDrv <= b;
      hold();
      sclLine <= 1'b1;
      hold();
      r = sdaLine;
      sclLine <= 1'b0;
      hold();
   endtask : bit_io
   task automatic start();
      sdaDrv <= 1'b1;
      hold();
      sclLine <= 1'b1;
      hold();
      sdaDrv <= 1'b0;
      hold();
      sclLine <= 1'b0;
      hold();
   endtask : start
   task automatic xfer(input logic [7:0] tx, input logic ackIn, input logic want,
                       output logic [7:0] rx);
      logic a;
      for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
      bit_io(ackIn, a);
      if (want && a) nackSeen = 1'b1;
   endtask : xfer
   task automatic stop_bus();
      sdaDrv <= 1'b0;
      hold();
      sclLine <= 1'b1;
      hold();
      sdaDrv <= 1'b1;
      hold();
   endtask : stop_bus
   // Pairs go out whole in one transaction
   // Callers never aim this at the variant register
   task automatic wr(input logic [7:0] cmd, input int n, input logic [15:0] d);
      logic [7:0] r;
      start();
      xfer({light_sensor_pkg::SLAVE_ADDR, 1'b0}, 1'b1, 1'b1, r);
      xfer(cmd, 1'b1, 1'b1, r);
      for (int i = 0; i < n; i++) xfer(d[8*i+:8], 1'b1, 1'b1, r);
      stop_bus();
   endtask : wr
   // Lower byte always fetched before upper
   task automatic rd(input logic [7:0] cmd, input int n, output logic [15:0] v);
      logic [7:0] r;
      v = 16'h0000;
      if (cmd[7]) begin
         start();
         xfer({light_sensor_pkg::SLAVE_ADDR, 1'b0}, 1'b1, 1'b1, r);
         xfer(cmd, 1'b1, 1'b1, r);
      end
      start();
      xfer({light_sensor_pkg::SLAVE_ADDR, 1'b1}, 1'b1, 1'b1, r);
      for (int i = 0; i < n; i++) begin
         xfer(8'hFF, i == n - 1, 1'b0, r);
         v[8*i+:8] = r;
      end
      // Plain stop: a dummy write would store its byte at the pointer
      stop_bus();
   endtask : rd
endmodule : i2c_host_model
`default_nettype wire

/* sim/tb_light_sensor_regs.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_light_sensor_regs;
   logic                    clk_sys = 1'b0;
   logic                    rst = 1'b1;
   logic                    sclIn, sdaIn, sdaOeN, intOeN, halt, nack;
   logic                    convDone = 1'b0;
   logic                    adcEnable = 1'b0;
   logic                    manualActive = 1'b0;
   light_sensor_pkg::conv_t convData = '0;
   light_sensor_pkg::gain_t gainSel;
   logic [15:0]             v;
   logic [47:0]             tv [4] = '{48'h0001_0150_FFFF, 48'h0000_0100_0150,
                                       48'h0001_0200_0000, 48'h0000_0201_0000};
   int                      failures = 0;
   int                      checks = 0;
   always #5 clk_sys = ~clk_sys;
   light_sensor_regs light_sensor_regs_i (.clk_sys(clk_sys), .rst(rst), .sclIn(sclIn),
      .sdaIn(sdaIn), .sdaOut(), .sdaOeN(sdaOeN), .intOut(), .intOeN(intOeN),
      .convDone(convDone), .convData(convData), .adcEnable(adcEnable),
      .manualActive(manualActive), .haltIntegration(halt), .gainSel(gainSel));
   i2c_host_model host (.clk_sys(clk_sys), .sdaOeN(sdaOeN), .sclLine(sclIn),
      .sdaLine(sdaIn), .nackSeen(nack));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic conv(input logic [15:0] c0, input logic [15:0] c1);
      convData <= '{c0, c1};
      convDone <= 1'b1;
      @(posedge clk_sys);
      convDone <= 1'b0;
      repeat (4) @(posedge clk_sys);
   endtask : conv
   task automatic final_report();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : final_report
   initial begin
      repeat (60000) @(posedge clk_sys);
      failures++;
      final_report();
   end
   initial begin
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      chk(16'({intOeN, halt, gainSel}), 16'h0008);
      for (int i = 0; i < 4; i++) begin
         host.rd(8'(8'h83 + 2 * i + (i > 1 ? 13 : 0)), 2, v);
         chk(v, 16'h0000);
      end
      host.wr(8'h92, 1, 16'h0000);
      host.rd(8'h92, 1, v);
      chk(v, 16'({light_sensor_pkg::PART_CODE, light_sensor_pkg::SILICON_REV}));
      host.rd(8'h9E, 1, v);
      chk(v, 16'({2'b00, light_sensor_pkg::VARIANT_CODE, 4'h0}));
      for (int g = 0; g < 8; g++) begin
         host.wr(8'h87, 1, 16'(g));
         chk(16'(gainSel), 16'(g % 4));
      end
      host.wr(8'h83, 2, 16'h0100);
      host.wr(8'h85, 2, 16'h0200);
      host.wr(8'h82, 1, 16'h0011);
      foreach (tv[i]) begin
         conv(tv[i][31:16], tv[i][15:0]);
         chk(16'(intOeN), tv[i][47:32]);
         host.wr(8'hE0, 0, 16'h0000);
         chk(16'(intOeN), 16'h0001);
      end
      // Second send byte would land in 05h if taken as data
      repeat (2) host.wr(8'h85, 0, 16'h0000);
      host.rd(8'h00, 2, v);
      chk(v, 16'h0200);
      for (int p = 2; p < 16; p++) begin
         host.wr(8'h82, 1, 16'(8'h10 + p));
         conv(16'h0150, 16'h0000);
         repeat (p - 1) conv(16'h0300, 16'h0000);
         chk(16'(intOeN), 16'h0001);
         conv(16'h0300, 16'h0000);
         chk(16'(intOeN), 16'h0000);
         host.wr(8'hE0, 0, 16'h0000);
      end
      host.wr(8'h82, 1, 16'h0010);
      conv(16'h0150, 16'h0000);
      chk(16'(intOeN), 16'h0000);
      // A pending left here would halt the converter at once later on
      host.wr(8'hE0, 0, 16'h0000);
      chk(16'(intOeN), 16'h0001);
      host.wr(8'h82, 1, 16'h0001);
      conv(16'h0300, 16'h0000);
      chk(16'(intOeN), 16'h0001);
      conv(16'hA1B2, 16'h5566);
      host.rd(8'h94, 1, v);
      chk(v, 16'h00B2);
      conv(16'hC3D4, 16'h7788);
      host.rd(8'h95, 1, v);
      chk(v, 16'h00A1);
      host.rd(8'h96, 2, v);
      chk(v, 16'h7788);
      host.wr(8'h82, 1, 16'h0051);
      adcEnable <= 1'b1;
      conv(16'h0300, 16'h0000);
      conv(16'h0150, 16'h0000);
      chk(16'({intOeN, halt}), 16'h0001);
      host.rd(8'h94, 1, v);
      chk(v, 16'h0000);
      adcEnable <= 1'b0;
      host.wr(8'hE0, 0, 16'h0000);
      chk(16'(halt), 16'h0000);
      manualActive <= 1'b1;
      repeat (3 * light_sensor_pkg::TIMER_UNIT_CYC + 20) @(posedge clk_sys);
      manualActive <= 1'b0;
      host.rd(8'h98, 2, v);
      chk(v, 16'h0003);
      chk(16'(nack), 16'h0000);
      final_report();
   end
endmodule : tb_light_sensor_regs
`default_nettype wire
